// File: design/dcc_dac_ctrl.sv
// Our own choices: the APB slave port and the placing of the registers.
`include "dcc_consts.svh"
`default_nettype none

// Operation
// - Two 8-bit data registers, cleared by reset/standby
// - Enabled channel converts its data once per data write or fresh enable, then holds
// - Control register resets to 0x1F
// - Bit 7 enables channel 1 conversion/output
// - Bit 6 enables channel 0 conversion/output
// - Bit 5 joins both channels' conversion
// - Enable table decides which channels convert
// - Pin drive follows own enable only
// - Control bits 4-0 read one, ignore writes
// - Standby register resets 0xFE, survives software standby
// - Standby bits 7-1 read as one
// - Bit 0 keeps outputs during software standby
// - Enabled standby output keeps all registers
// - Data write restarts conversion immediately
// - Output code equals data register unchanged
// - Enable makes pin output, clear returns input
// - Conversion finishes within 10 us
module dcc_dac_ctrl
    import dcc_pkg::*;
#(
    parameter int CONV_CYCLES = `DCC_CONV_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_standby,
    input wire logic sw_standby,
    output dcc_chan_out_s analog_out_chan0,
    output dcc_chan_out_s analog_out_chan1
);

    // =====================================================
    // Local sizes
    localparam int CNT_W = $clog2(CONV_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CONV_CYCLES - 1);

    // =====================================================
    // Functions

    // Address match against one register byte address
    function automatic logic addr_is(input logic [17:0] a, input logic [17:0] reg_addr);
        addr_is = (a == reg_addr);
    endfunction

    // A channel converts on its own enable or, when joined, on the other's
    function automatic logic chan_conv(input logic own, input logic other, input logic joint);
        chan_conv = own | (other & joint);
    endfunction

    // =====================================================
    // Declarations
    logic hw_meta;
    logic hw_sync;
    logic sw_meta;
    logic sw_sync;
    logic sw_prev;
    logic [7:0] data_reg [2];
    dcc_ctrl_s ctrl;
    logic ste;
    dcc_conv_state_e state [2];
    logic [CNT_W-1:0] cnt [2];
    logic conv_q [2];
    dcc_chan_out_s chan_out [2];
    logic stby_clear;
    logic wr_acc;
    logic setup;
    logic data_wr [2];
    logic conv_en [2];
    logic pin_en [2];
    logic start [2];
    logic finish [2];
    logic own_oe [2];
    logic [31:0] next_prdata;
    logic next_pslverr;

    // =====================================================
    // Standby pin synchronisers

    // Two flops per pin; only the second one is read by logic
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hw_meta <= 1'b0;
            hw_sync <= 1'b0;
            sw_meta <= 1'b0;
            sw_sync <= 1'b0;
        end
        else
        begin
            hw_meta <= hw_standby;
            hw_sync <= hw_meta;
            sw_meta <= sw_standby;
            sw_sync <= sw_meta;
        end
    end

    // Previous software standby level, for entry detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sw_prev <= 1'b0;
        end
        else
        begin
            sw_prev <= sw_sync;
        end
    end

    // Hardware standby clears for its whole duration; software standby
    // clears only on entry, and not at all when outputs are kept alive
    assign stby_clear = hw_sync | (sw_sync & ~sw_prev & ~ste);

    // =====================================================
    // Bus strobes and channel decode
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pready & pwrite & pstrb[0];
    assign data_wr[0] = wr_acc & addr_is(paddr, `DCC_ADDR_DATA0);
    assign data_wr[1] = wr_acc & addr_is(paddr, `DCC_ADDR_DATA1);
    assign own_oe[0] = ctrl.oe0;
    assign own_oe[1] = ctrl.oe1;

    // Conversion enable from the enable table
    assign conv_en[0] = chan_conv(ctrl.oe0, ctrl.oe1, ctrl.joint);
    assign conv_en[1] = chan_conv(ctrl.oe1, ctrl.oe0, ctrl.joint);

    // Per-channel start, finish and pin permission
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            // A data write or a fresh enable starts conversion at once
            start[i] = conv_en[i] & (data_wr[i] | ~conv_q[i]);
            finish[i] = (state[i] == DCC_CONV) && (cnt[i] == '0);
            // Own enable only; joint bit never drives a pin
            pin_en[i] = own_oe[i] & ~hw_sync & (~sw_sync | ste);
        end
    end

    // =====================================================
    // Data registers

    // Cleared by reset, throughout hardware standby and on software standby entry unless ste is set, held otherwise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_reg[0] <= `DCC_DATA_RST;
            data_reg[1] <= `DCC_DATA_RST;
        end
        else if (stby_clear)
        begin
            data_reg[0] <= `DCC_DATA_RST;
            data_reg[1] <= `DCC_DATA_RST;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (data_wr[i])
                begin
                    data_reg[i] <= pwdata[7:0];
                end
            end
        end
    end

    // =====================================================
    // Converter control register

    // Only the three upper bits store; the low five are constant ones
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= dcc_ctrl_s'(3'(`DCC_CTRL_RST >> 5));
        end
        else if (stby_clear)
        begin
            ctrl <= dcc_ctrl_s'(3'(`DCC_CTRL_RST >> 5));
        end
        else if (wr_acc && addr_is(paddr, `DCC_ADDR_CTRL))
        begin
            ctrl.oe1 <= pwdata[`DCC_BIT_OE1];
            ctrl.oe0 <= pwdata[`DCC_BIT_OE0];
            ctrl.joint <= pwdata[`DCC_BIT_JOINT];
        end
    end

    // =====================================================
    // Standby control register

    // Cleared by reset and hardware standby only; a software standby
    // entry must not touch it, or the keep-alive choice would be lost
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ste <= 1'(`DCC_STBY_RST & 8'h01);
        end
        else if (hw_sync)
        begin
            ste <= 1'(`DCC_STBY_RST & 8'h01);
        end
        else if (wr_acc && addr_is(paddr, `DCC_ADDR_STBY))
        begin
            ste <= pwdata[`DCC_BIT_STE];
        end
    end

    // =====================================================
    // Conversion sequencers

    // Enable history, so a fresh enable is seen as a start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conv_q[0] <= 1'b0;
            conv_q[1] <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                conv_q[i] <= conv_en[i] & ~stby_clear;
            end
        end
    end

    // Countdown of the conversion time; a restart reloads the count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state[0] <= DCC_IDLE;
            state[1] <= DCC_IDLE;
            cnt[0] <= '0;
            cnt[1] <= '0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (stby_clear || !conv_en[i])
                begin
                    state[i] <= DCC_IDLE;
                    cnt[i] <= '0;
                end
                else if (start[i])
                begin
                    state[i] <= DCC_CONV;
                    cnt[i] <= CNT_LOAD;
                end
                else
                begin
                    case (state[i])
                        DCC_CONV:
                        begin
                            if (cnt[i] == '0)
                            begin
                                state[i] <= DCC_HOLD;
                            end
                            else
                            begin
                                cnt[i] <= cnt[i] - 1'b1;
                            end
                        end
                        DCC_HOLD:
                        begin
                            state[i] <= DCC_HOLD;
                        end
                        default:
                        begin
                            state[i] <= DCC_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // =====================================================
    // Output codes and pin drive

    // The old result stays valid while a rewrite converts, as the
    // analog level only moves once the new conversion completes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chan_out[0] <= '0;
            chan_out[1] <= '0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                chan_out[i].drive <= pin_en[i] & ~stby_clear;
                if (stby_clear || !conv_en[i])
                begin
                    chan_out[i].valid <= 1'b0;
                end
                else if (finish[i])
                begin
                    chan_out[i].valid <= 1'b1;
                    chan_out[i].code <= data_reg[i];
                end
            end
        end
    end

    assign analog_out_chan0 = chan_out[0];
    assign analog_out_chan1 = chan_out[1];

    // =====================================================
    // APB read decode

    // Read data is captured in the setup cycle and shown in access
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (addr_is(paddr, `DCC_ADDR_DATA0))
        begin
            next_prdata[7:0] = data_reg[0];
        end
        else if (addr_is(paddr, `DCC_ADDR_DATA1))
        begin
            next_prdata[7:0] = data_reg[1];
        end
        else if (addr_is(paddr, `DCC_ADDR_CTRL))
        begin
            next_prdata[7:0] = {ctrl.oe1, ctrl.oe0, ctrl.joint, `DCC_CTRL_RSVD};
        end
        else if (addr_is(paddr, `DCC_ADDR_STBY))
        begin
            next_prdata[7:0] = {`DCC_STBY_RSVD, ste};
        end
        else if (addr_is(paddr, `DCC_ADDR_STAT))
        begin
            next_prdata[5:0] = {chan_out[1].drive, chan_out[0].drive,
                                chan_out[1].valid, chan_out[0].valid,
                                state[1] == DCC_CONV, state[0] == DCC_CONV};
        end
        else
        begin
            next_pslverr = 1'b1;
        end
        if (pwrite)
        begin
            next_prdata = 32'h0000_0000;
        end
    end

    // =====================================================
    // APB handshake

    // One access cycle per transfer; ready is a flop so it is glitch free
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            pready <= 1'b1;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
        else
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// File: design/dcc_consts.svh
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ==========================================
// Register indices; byte address is four times the index
`define DCC_IDX_DATA0 16'hffdc
`define DCC_IDX_DATA1 16'hffdd
`define DCC_IDX_CTRL 16'hffde
`define DCC_IDX_STAT 16'hffdf
`define DCC_IDX_STBY 16'hff5c
`define DCC_ADDR_DATA0 ({`DCC_IDX_DATA0, 2'b00})
`define DCC_ADDR_DATA1 ({`DCC_IDX_DATA1, 2'b00})
`define DCC_ADDR_CTRL ({`DCC_IDX_CTRL, 2'b00})
`define DCC_ADDR_STAT ({`DCC_IDX_STAT, 2'b00})
`define DCC_ADDR_STBY ({`DCC_IDX_STBY, 2'b00})

// ==========================================
// Reset values and reserved masks
`define DCC_DATA_RST 8'h00
`define DCC_CTRL_RST 8'h1f
`define DCC_STBY_RST 8'hfe
`define DCC_CTRL_RSVD 5'h1f
`define DCC_STBY_RSVD 7'h7f

// ==========================================
// Field positions
`define DCC_BIT_OE1 7
`define DCC_BIT_OE0 6
`define DCC_BIT_JOINT 5
`define DCC_BIT_STE 0

// ==========================================
// Timing: longest conversion time, rounded down to cycles
`define DCC_CLK_NS 20
`define DCC_CONV_TIME_NS 10000
`define DCC_CONV_CYCLES (`DCC_CONV_TIME_NS / `DCC_CLK_NS)

`endif

// File: design/dcc_pkg.sv
`default_nettype none

package dcc_pkg;

    // Conversion state of one channel
    typedef enum logic [2:0]
    {
        DCC_IDLE = 3'b001,
        DCC_CONV = 3'b010,
        DCC_HOLD = 3'b100
    } dcc_conv_state_e;

    // Converter control fields
    typedef struct packed
    {
        logic oe1;
        logic oe0;
        logic joint;
    } dcc_ctrl_s;

    // What one analog output pin sees
    typedef struct packed
    {
        logic drive;
        logic valid;
        logic [7:0] code;
    } dcc_chan_out_s;

endpackage

`default_nettype wire

// File: tb/dcc_dac_ctrl_sva.sv
`include "dcc_consts.svh"
`default_nettype none
// ==========================================
// Port watcher for the converter control block
module dcc_dac_ctrl_chk
    import dcc_pkg::*;
#(
    parameter int CONV_CYCLES = 5
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire dcc_chan_out_s analog_out_chan0,
    input wire dcc_chan_out_s analog_out_chan1
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_ctrl;
    logic rd_now;
    // Accepted accesses; standby inputs pass a sync, so drive checks wait for quiet
    assign wr_ctrl = pready && pwrite && pstrb[0] && paddr == `DCC_ADDR_CTRL;
    assign rd_now = pready && !pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (psel && !penable |=> pready && penable)
        else $error("pready missing after setup");
    upper_zero_a: assert property (rd_now |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    ctrl_rsvd_a: assert property (rd_now && paddr == `DCC_ADDR_CTRL |-> prdata[4:0] == 5'h1f)
        else $error("control reserved bits not one");
    stby_rsvd_a: assert property (rd_now && paddr == `DCC_ADDR_STBY |-> prdata[7:1] == 7'h7f)
        else $error("standby reserved bits not one");
    drive_zero_a: assert property (wr_ctrl && !$past(hw_standby, 3) && !$past(sw_standby, 3)
        |-> ##2 analog_out_chan0.drive == $past(pwdata[6], 2))
        else $error("channel 0 drive does not follow its enable");
    drive_one_a: assert property (wr_ctrl && !$past(hw_standby, 3) && !$past(sw_standby, 3)
        |-> ##2 analog_out_chan1.drive == $past(pwdata[7], 2))
        else $error("channel 1 drive does not follow its enable");
    valid_delay_a: assert property ($rose(analog_out_chan0.valid) |->
        !$past(analog_out_chan0.valid, CONV_CYCLES))
        else $error("result valid earlier than conversion time");
    code_hold_a: assert property ($changed(analog_out_chan0.code) |->
        analog_out_chan0.valid || analog_out_chan0.code == 8'h00)
        else $error("code changed without a new result");
    hw_stby_a: assert property (hw_standby [*5] |->
        !analog_out_chan0.drive && !analog_out_chan1.drive)
        else $error("pin driven in hardware standby");
    cover property (wr_ctrl);
    cover property ($rose(analog_out_chan1.valid));
    cover property (pslverr);
endmodule

bind dcc_dac_ctrl dcc_dac_ctrl_chk #(.CONV_CYCLES(CONV_CYCLES)) i_dcc_dac_ctrl_chk (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .hw_standby, .sw_standby, .analog_out_chan0, .analog_out_chan1);
`default_nettype wire

// File: tb/dcc_analog_load.sv
`default_nettype none
// ==========================================
// Load on both analog pins, level in millivolts
module dcc_analog_load
    import dcc_pkg::*;
#(
    parameter int VREF_MV = 2560
)
(
    input wire logic pclk,
    input wire dcc_chan_out_s pin0,
    input wire dcc_chan_out_s pin1,
    output logic [15:0] level0,
    output logic [15:0] level1
);
    timeunit 1ns;
    timeprecision 1ns;
    // A released pin floats: show the inverse so no stale level passes
    always @(posedge pclk)
    begin
        level0 <= (pin0.drive && pin0.valid) ? 16'(pin0.code * VREF_MV / 256) : ~level0;
        level1 <= (pin1.drive && pin1.valid) ? 16'(pin1.code * VREF_MV / 256) : ~level1;
    end
endmodule
`default_nettype wire

// File: tb/dcc_dac_ctrl_tb_top.sv
`include "dcc_consts.svh"
`default_nettype none
// ==========================================
// Register-level bench for the converter control block
module dcc_dac_ctrl_tb_top
    import dcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CONV = 5;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hw_standby, sw_standby, err;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [15:0] level0, level1;
    dcc_chan_out_s analog_out_chan0, analog_out_chan1;
    int fails, checked, cycles;
    dcc_dac_ctrl #(.CONV_CYCLES(CONV)) i_dcc_dac_ctrl (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .hw_standby, .sw_standby,
        .analog_out_chan0, .analog_out_chan1);
    dcc_analog_load i_dcc_analog_load (.pclk, .pin0(analog_out_chan0),
        .pin1(analog_out_chan1), .level0, .level1);
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // One APB transfer; request held until pready is seen
    task automatic apb(input logic [17:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        apb(a, 1'b1, {24'h0, d}, 4'hf);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic rdchk(input string n, input logic [17:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0, 4'h0);
        chk(n, e, rd);
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            give_verdict();
        end
    end
    initial
    begin
        {presetn, psel, penable, pwrite, hw_standby, sw_standby, err} = 7'h0;
        {paddr, pwdata, pstrb} = 54'h0;
        {fails, checked, cycles} = 96'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("data0", `DCC_ADDR_DATA0, 32'h0);
        rdchk("data1", `DCC_ADDR_DATA1, 32'h0);
        rdchk("ctrl", `DCC_ADDR_CTRL, 32'h1f);
        rdchk("stby", `DCC_ADDR_STBY, 32'hfe);
        $display("test reset done");
        wr(`DCC_ADDR_CTRL, 8'h00);
        rdchk("ctrl rsvd", `DCC_ADDR_CTRL, 32'h1f);
        wr(`DCC_ADDR_STBY, 8'h00);
        rdchk("stby rsvd", `DCC_ADDR_STBY, 32'hfe);
        apb(`DCC_ADDR_DATA0, 1'b1, 32'h5a, 4'h0);
        rdchk("no strobe", `DCC_ADDR_DATA0, 32'h0);
        apb(18'h0, 1'b0, 32'h0, 4'h0);
        chk1("unmapped", 1'b1, err);
        $display("test access done");
        wr(`DCC_ADDR_DATA0, 8'h5a);
        wr(`DCC_ADDR_DATA1, 8'ha5);
        rdchk("data1 rw", `DCC_ADDR_DATA1, 32'ha5);
        // Every enable and joint combination
        for (int k = 0; k < 8; k++)
        begin
            wr(`DCC_ADDR_CTRL, 8'h00);
            repeat (3) @(posedge pclk);
            wr(`DCC_ADDR_CTRL, {k[2:0], 5'h0});
            repeat (CONV + 3) @(posedge pclk);
            chk1("valid0", k[1] | (k[2] & k[0]), analog_out_chan0.valid);
            chk1("valid1", k[2] | (k[1] & k[0]), analog_out_chan1.valid);
            chk1("drive0", k[1], analog_out_chan0.drive);
            chk1("drive1", k[2], analog_out_chan1.drive);
        end
        chk("code0", 32'h5a, {24'h0, analog_out_chan0.code});
        chk("level1", 32'ha5 * 32'ha00 / 32'h100, {16'h0, level1});
        // Both pins driven, both results present, neither converting
        rdchk("status", `DCC_ADDR_STAT, 32'h3c);
        $display("test enables done");
        wr(`DCC_ADDR_DATA0, 8'h11);
        repeat (3) @(posedge pclk);
        chk("code0 old", 32'h5a, {24'h0, analog_out_chan0.code});
        chk1("valid0 held", 1'b1, analog_out_chan0.valid);
        repeat (3) @(posedge pclk);
        chk("code0 new", 32'h11, {24'h0, analog_out_chan0.code});
        $display("test rewrite done");
        sw_standby <= 1'b1;
        repeat (6) @(posedge pclk);
        chk1("drive0 sw", 1'b0, analog_out_chan0.drive);
        chk1("drive1 sw", 1'b0, analog_out_chan1.drive);
        sw_standby <= 1'b0;
        repeat (6) @(posedge pclk);
        rdchk("data0 sw", `DCC_ADDR_DATA0, 32'h0);
        rdchk("ctrl sw", `DCC_ADDR_CTRL, 32'h1f);
        $display("test sw standby done");
        wr(`DCC_ADDR_STBY, 8'h01);
        wr(`DCC_ADDR_DATA0, 8'h77);
        wr(`DCC_ADDR_CTRL, 8'h40);
        repeat (CONV + 3) @(posedge pclk);
        sw_standby <= 1'b1;
        repeat (6) @(posedge pclk);
        chk1("drive0 keep", 1'b1, analog_out_chan0.drive);
        chk("level0 keep", 32'h77 * 32'ha00 / 32'h100, {16'h0, level0});
        sw_standby <= 1'b0;
        repeat (6) @(posedge pclk);
        rdchk("data0 keep", `DCC_ADDR_DATA0, 32'h77);
        rdchk("ctrl keep", `DCC_ADDR_CTRL, 32'h5f);
        rdchk("stby keep", `DCC_ADDR_STBY, 32'hff);
        $display("test keep alive done");
        hw_standby <= 1'b1;
        repeat (8) @(posedge pclk);
        chk1("drive0 hw", 1'b0, analog_out_chan0.drive);
        hw_standby <= 1'b0;
        repeat (6) @(posedge pclk);
        rdchk("stby hw", `DCC_ADDR_STBY, 32'hfe);
        rdchk("data0 hw", `DCC_ADDR_DATA0, 32'h0);
        rdchk("ctrl hw", `DCC_ADDR_CTRL, 32'h1f);
        $display("test hw standby done");
        give_verdict();
    end
endmodule
`default_nettype wire
